// ==== src/csc_pkg.sv ====
/*
  constants and types shared by the camera sensor capture block:
  timing mode encoding, embedded sync code layout, reset values and
  default sizes. assumes nothing of its surroundings.
*/
package csc_pkg;

  // sensor timing modes selectable by software
  typedef enum logic [1:0] {
    CSC_MODE_EMBEDDED,
    CSC_MODE_GATED,
    CSC_MODE_NONGATED
  } csc_mode_e;

  // default sizes of the pixel path
  localparam int unsigned CSC_DATA_W_DEF     = 8;
  localparam int unsigned CSC_FIFO_DEPTH_DEF = 2;
  localparam int unsigned CSC_CODE_W         = 8;

  // embedded sync code: preamble bytes and status byte fields
  localparam logic [7:0]  CSC_CODE_ONES      = 8'hff;
  localparam logic [7:0]  CSC_CODE_ZERO      = 8'h00;
  localparam int unsigned CSC_CODE_H_BIT     = 4;
  localparam int unsigned CSC_CODE_V_BIT     = 5;

  // reset values of control state
  localparam logic        CSC_LINE_ACT_RST   = 1'b0;
  localparam logic        CSC_FRAME_SEEN_RST = 1'b0;
  localparam logic        CSC_VBLANK_RST     = 1'b1;
  localparam logic        CSC_OVERFLOW_RST   = 1'b0;

endpackage

// ==== src/csc_capture.sv ====
/*
  camera sensor capture: frames pixel words from a parallel sensor port
  and hands them on through a small fifo and a registered output stage.
  assumes every sensor pin is asynchronous to sys_clk and that the pixel
  clock runs well below a quarter of sys_clk, so each of its levels is
  seen by at least two sys_clk edges after the synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - three modes: embedded codes, gated, non-gated
// - gated mode frames with frame, line, pixel clock
// - frame sync active edge starts each frame
// - gated: pixel edges valid only during line sync
// - data sampled on rising pixel clock edge
// - line sync low stops data acceptance
// - non-gated mode ignores line sync
// - non-gated: every pixel edge after frame start is captured
// - selectable frame, line, pixel clock polarities
// - invert bit moves sampling to falling edge
module csc_capture #(
  parameter int unsigned DATA_W     = csc_pkg::CSC_DATA_W_DEF,
  parameter int unsigned FIFO_DEPTH = csc_pkg::CSC_FIFO_DEPTH_DEF
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // sensor pins
  input  wire logic              sensor_frame_sync,
  input  wire logic              sensor_line_sync,
  input  wire logic              sensor_pixel_clock,
  input  wire logic [DATA_W-1:0] sensor_data,
  // configuration
  input  wire logic              capture_enable,
  input  wire csc_pkg::csc_mode_e timing_mode,
  input  wire logic              frame_sync_falling,
  input  wire logic              line_sync_active_low,
  input  wire logic              pixel_clock_invert,
  input  wire logic              overflow_clear,
  // pixel stream out
  output logic [DATA_W-1:0]      out_data,
  output logic                   out_frame_start,
  output logic                   out_valid,
  input  wire logic              out_ready,
  // status
  output logic                   line_active,
  output logic                   fifo_overflow
);
  import csc_pkg::*;

  localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);

  // refuse sizes the code detector or fifo cannot serve
  generate
    if (DATA_W < CSC_CODE_W) begin : g_bad_width
      $error("csc_capture: DATA_W must be at least 8");
    end
    if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("csc_capture: FIFO_DEPTH must be at least 2");
    end
  endgenerate

  // next pointer value with wrap, used by both fifo ends
  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    ptr_next = (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  // two-stage synchronisers; stage one is read only by stage two
  logic              fs_m_q, fs_s_q;
  logic              ls_m_q, ls_s_q;
  logic              pc_m_q, pc_s_q;
  logic [DATA_W-1:0] dat_m_q, dat_s_q;
  logic              pc_prev_q, fs_prev_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fs_m_q    <= 1'b0;
      fs_s_q    <= 1'b0;
      ls_m_q    <= 1'b0;
      ls_s_q    <= 1'b0;
      pc_m_q    <= 1'b0;
      pc_s_q    <= 1'b0;
      dat_m_q   <= '0;
      dat_s_q   <= '0;
      pc_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
    end else begin
      fs_m_q    <= sensor_frame_sync;
      fs_s_q    <= fs_m_q;
      ls_m_q    <= sensor_line_sync;
      ls_s_q    <= ls_m_q;
      pc_m_q    <= sensor_pixel_clock;
      pc_s_q    <= pc_m_q;
      dat_m_q   <= sensor_data;
      dat_s_q   <= dat_m_q;
      pc_prev_q <= pc_s_q;
      fs_prev_q <= fs_s_q;
    end
  end

  // edge and level decode after polarity selection
  logic pix_edge;
  logic frame_edge;
  logic ls_level;
  logic [CSC_CODE_W-1:0] code_byte;

  // data and pins share one synchroniser depth, so they stay aligned
  assign pix_edge   = pixel_clock_invert ? (pc_prev_q & ~pc_s_q)
                                         : (~pc_prev_q & pc_s_q);
  assign frame_edge = frame_sync_falling ? (fs_prev_q & ~fs_s_q)
                                         : (~fs_prev_q & fs_s_q);
  assign ls_level   = ls_s_q ^ line_sync_active_low;
  assign code_byte  = dat_s_q[DATA_W-1 -: CSC_CODE_W];

  // embedded mode: track the three preamble bytes of a sync code
  logic [1:0] pre_cnt_q;
  logic       emb_act_q;
  logic       emb_vblank_q;
  logic       emb_code;
  logic       emb_sof;

  assign emb_code = (pre_cnt_q == 2'd3);
  // frame starts where a start-of-line code ends vertical blanking
  assign emb_sof  = pix_edge & emb_code & ~code_byte[CSC_CODE_H_BIT] &
                    ~code_byte[CSC_CODE_V_BIT] & emb_vblank_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_q    <= 2'd0;
      emb_act_q    <= CSC_LINE_ACT_RST;
      emb_vblank_q <= CSC_VBLANK_RST;
    end else if (pix_edge) begin
      if (emb_code) begin
        pre_cnt_q    <= 2'd0;
        emb_act_q    <= ~code_byte[CSC_CODE_H_BIT];
        emb_vblank_q <= code_byte[CSC_CODE_V_BIT];
      end else if (code_byte == CSC_CODE_ONES) begin
        pre_cnt_q <= 2'd1;
      end else if (code_byte == CSC_CODE_ZERO && pre_cnt_q != 2'd0) begin
        pre_cnt_q <= pre_cnt_q + 2'd1;
      end else begin
        pre_cnt_q <= 2'd0;
      end
    end
  end

  // mode select: which pixel edges carry a word
  logic frame_start;
  logic word_ok;

  always_comb begin
    frame_start = 1'b0;
    word_ok     = 1'b0;
    case (timing_mode)
      CSC_MODE_EMBEDDED: begin
        frame_start = emb_sof;
        // reserved code values never carry pixels
        word_ok     = emb_act_q & ~emb_code &
                      (code_byte != CSC_CODE_ONES) &
                      (code_byte != CSC_CODE_ZERO);
      end
      CSC_MODE_GATED: begin
        frame_start = frame_edge;
        word_ok     = ls_level;
      end
      CSC_MODE_NONGATED: begin
        frame_start = frame_edge;
        word_ok     = 1'b1;
      end
      default: begin
        frame_start = 1'b0;
        word_ok     = 1'b0;
      end
    endcase
  end

  // frame tracking: words are taken only after a frame has begun
  logic frame_seen_q;
  logic sof_pend_q;
  logic cap_valid;

  assign cap_valid = capture_enable & pix_edge & word_ok &
                     (frame_seen_q | frame_start);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_seen_q <= CSC_FRAME_SEEN_RST;
      sof_pend_q   <= 1'b0;
    end else if (!capture_enable) begin
      frame_seen_q <= CSC_FRAME_SEEN_RST;
      sof_pend_q   <= 1'b0;
    end else if (frame_start) begin
      frame_seen_q <= 1'b1;
      sof_pend_q   <= ~cap_valid;
    end else if (cap_valid) begin
      sof_pend_q   <= 1'b0;
    end
  end

  // input fifo; the sensor cannot be stalled, so a full fifo drops
  logic [DATA_W:0]  mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [CNT_W-1:0] cnt_q;
  logic             fifo_full, fifo_empty;
  logic             fifo_wr, fifo_rd;

  assign fifo_full  = (cnt_q == CNT_FULL);
  assign fifo_empty = (cnt_q == '0);
  assign fifo_wr    = cap_valid & ~fifo_full;
  // output stage pulls whenever it is empty or being drained
  assign fifo_rd    = ~fifo_empty & (~out_valid | out_ready);

  always_ff @(posedge sys_clk) begin
    if (fifo_wr) begin
      mem_q[wr_ptr_q] <= {sof_pend_q | frame_start, dat_s_q};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (fifo_wr) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (fifo_rd) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      if (fifo_wr && !fifo_rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (fifo_rd && !fifo_wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // registered output stage, held while the receiver stalls
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_valid       <= 1'b0;
      out_data        <= '0;
      out_frame_start <= 1'b0;
    end else if (fifo_rd) begin
      out_valid       <= 1'b1;
      out_data        <= mem_q[rd_ptr_q][DATA_W-1:0];
      out_frame_start <= mem_q[rd_ptr_q][DATA_W];
    end else if (out_ready) begin
      out_valid       <= 1'b0;
    end
  end

  // status: overflow is sticky, a new drop wins over the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fifo_overflow <= CSC_OVERFLOW_RST;
      line_active   <= CSC_LINE_ACT_RST;
    end else begin
      if (cap_valid && fifo_full) begin
        fifo_overflow <= 1'b1;
      end else if (overflow_clear) begin
        fifo_overflow <= 1'b0;
      end
      line_active <= word_ok & frame_seen_q;
    end
  end

endmodule

`default_nettype wire

// ==== bench/csc_capture_checker.sv ====
/* port assertions for the capture block, bound into each instance.
   assumes sys_clk is the only clock and rst clears all state. */
`timescale 1ns/1ps
`default_nettype none
module csc_capture_checker
  import csc_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic              sensor_line_sync,
  input wire logic              capture_enable,
  input wire csc_mode_e         timing_mode,
  input wire logic              line_sync_active_low,
  input wire logic              overflow_clear,
  input wire logic [DATA_W-1:0] out_data,
  input wire logic              out_frame_start,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire logic              fifo_overflow
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a held word keeps value and flag until taken
  property p_hold; out_valid && !out_ready |=> out_valid; endproperty
  property p_data; out_valid && !out_ready |=> $stable(out_data); endproperty
  property p_fst;
    out_valid && !out_ready |=> $stable(out_frame_start);
  endproperty
  // drop flag is sticky and needs a full path
  property p_keep; fifo_overflow && !overflow_clear |=> fifo_overflow;
  endproperty
  property p_set; $rose(fifo_overflow) |-> $past(out_valid); endproperty
  // 8 cycles of steady refusal drain the path, late words would show
  property p_off; (!capture_enable && out_ready)[*8] |-> !out_valid;
  endproperty
  property p_none; (timing_mode == 2'd3 && out_ready)[*8] |-> !out_valid;
  endproperty
  property p_gate;
    (capture_enable && out_ready && timing_mode == CSC_MODE_GATED &&
     sensor_line_sync == line_sync_active_low)[*8] |-> !out_valid;
  endproperty
  a_hold: assert property (p_hold)
    else $error("held word lost");
  a_data: assert property (p_data)
    else $error("held data moved");
  a_fst: assert property (p_fst)
    else $error("held flag moved");
  a_keep: assert property (p_keep)
    else $error("drop flag lost");
  a_set: assert property (p_set)
    else $error("drop with room");
  a_off: assert property (p_off)
    else $error("word while off");
  a_none: assert property (p_none)
    else $error("word in no mode");
  a_gate: assert property (p_gate)
    else $error("word outside line");
  c_frame: cover property (out_valid && out_ready && out_frame_start);
  c_drop: cover property ($rose(fifo_overflow));
  c_stall: cover property ((out_valid && !out_ready)[*4]);
  c_emb: cover property (timing_mode == CSC_MODE_EMBEDDED && out_valid);
endmodule
bind csc_capture csc_capture_checker #(.DATA_W(DATA_W)) u_chk (
  .sys_clk, .rst, .sensor_line_sync, .capture_enable, .timing_mode,
  .line_sync_active_low, .overflow_clear, .out_data, .out_frame_start,
  .out_valid, .out_ready, .fifo_overflow);
`default_nettype wire

// ==== bench/csc_sensor.sv ====
/* sensor model: syncs, pixel clock and data words.
   assumes its tasks are called from sys_clk edge code. */
`timescale 1ns/1ps
`default_nettype none
module csc_sensor (
  input  wire logic       sys_clk,
  input  wire logic [2:0] cfg,
  input  wire logic       ls_use,
  output logic            fs,
  output logic            ls,
  output logic            pc,
  output logic [7:0]      d
);
  // cfg: clock invert, frame sync falling, line sync low
  initial {fs, ls, pc, d} = '0;
  // sync levels under the chosen polarities
  task automatic sync(input logic f, input logic l);
    @(posedge sys_clk) begin
      fs <= f ^ cfg[1];
      ls <= (l & ls_use) ^ cfg[0];
    end
  endtask
  // data moves on the idle edge, 80 ns from the active one
  task automatic word(input logic [7:0] w);
    @(posedge sys_clk) {d, pc} <= {w, cfg[2]};
    repeat (3) @(posedge sys_clk);
    @(posedge sys_clk) pc <= ~cfg[2];
    repeat (3) @(posedge sys_clk);
  endtask
  // clock parked low, released bus shows the inverse
  task automatic idle;
    @(posedge sys_clk) {d, pc} <= {~d, 1'b0};
  endtask
endmodule
`default_nettype wire

// ==== bench/csc_capture_bench.sv ====
/* bench: sensor model on the pins, noted words checked at the output.
   assumes csc_pkg and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module csc_capture_bench;
  import csc_pkg::*;
  logic sys_clk = 0, rst = 1, en = 0, ovc = 0, out_ready = 0, stall = 0;
  logic [2:0] cfg = 0;
  csc_mode_e mode = CSC_MODE_GATED;
  logic fs, ls, pc, fst, ov, vld, lact;
  logic [7:0] sd, od;
  logic [8:0] q[$];
  int num_errors = 0, n_checks = 0, cyc = 0, k, i;
  int seed = 32'h9710;
  // embedded stream: clearing byte, blanking code, start code, two
  // words, end code, then one word that comes after the end code
  logic [127:0] emb = 128'h11ff0000b0ff0000805a3cff000090a5;
  always #10 sys_clk = ~sys_clk;
  csc_capture uut (.sys_clk, .rst, .sensor_frame_sync(fs),
    .sensor_line_sync(ls), .sensor_pixel_clock(pc), .sensor_data(sd),
    .capture_enable(en), .timing_mode(mode), .frame_sync_falling(cfg[1]),
    .line_sync_active_low(cfg[0]), .pixel_clock_invert(cfg[2]),
    .overflow_clear(ovc), .out_data(od), .out_frame_start(fst),
    .out_valid(vld), .out_ready, .line_active(lact), .fifo_overflow(ov));
  csc_sensor sen (.sys_clk, .cfg, .ls_use(mode != CSC_MODE_NONGATED),
    .fs, .ls, .pc, .d(sd));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // given word, noted only when it should be taken
  task automatic ew(input logic take, input logic f, input logic [7:0] w);
    if (take) q.push_back({f, w});
    sen.word(w);
  endtask
  // random word, noted only when it should be taken
  task automatic px(input logic take, input logic f);
    logic [7:0] w;
    w = 8'($random(seed));
    ew(take, f, w);
  endtask
  // disabled while polarities move; a word now must be refused
  task automatic setup(input csc_mode_e m, input logic [2:0] c);
    @(posedge sys_clk) begin
      en <= 1'b0;
      mode <= m;
      cfg <= c;
    end
    sen.sync(1'b0, 1'b1);
    px(1'b0, 1'b0);
    repeat (8) @(posedge sys_clk);
    en <= 1'b1;
  endtask
  // each handshake takes the oldest note
  always @(posedge sys_clk) begin
    out_ready <= !stall;
    if (!rst && vld === 1'b1 && out_ready === 1'b1)
      chk({fst, od}, q.size() ? q.pop_front() : 'x);
  end
  // hang guard, runs need about 2000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 10000) begin
      num_errors++;
      test_done;
    end
  end
  // gated and non-gated under every polarity mix, then embedded codes, then a full buffer, then no mode
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (k = 0; k < 16; k++) begin
      setup(k[0] ? CSC_MODE_NONGATED : CSC_MODE_GATED, 3'(k >> 1));
      px(1'b0, 1'b0);
      sen.sync(1'b1, 1'b1);
      for (i = 0; i < 6; i++) begin
        if (i == 3) begin
          if (!k[0]) chk(9'(lact), 9'd1);
          sen.idle;
          sen.sync(1'b1, 1'b0);
          px(k[0], 1'b0);
          if (!k[0]) chk(9'(lact), 9'd0);
          sen.idle;
          sen.sync(1'b1, 1'b1);
        end
        px(1'b1, i == 0);
      end
      sen.idle;
      sen.sync(1'b0, 1'b1);
      repeat (20) @(posedge sys_clk);
      $display("test %0d done", k);
    end
    // code bytes and reserved values are never taken as pixels
    setup(CSC_MODE_EMBEDDED, 3'd0);
    for (i = 0; i < 16; i++)
      ew(i == 9 || i == 10, i == 9, emb[8*(15-i) +: 8]);
    repeat (20) @(posedge sys_clk);
    $display("embedded test done");
    stall <= 1'b1;
    setup(CSC_MODE_GATED, 3'd0);
    sen.sync(1'b1, 1'b1);
    for (i = 0; i < 4; i++) px(i < 3, i == 0);
    repeat (6) @(posedge sys_clk);
    chk(9'(ov), 9'd1);
    ovc <= 1'b1;
    @(posedge sys_clk) ovc <= 1'b0;
    @(posedge sys_clk) chk(9'(ov), 9'd0);
    stall <= 1'b0;
    $display("buffer test done");
    setup(csc_mode_e'(2'd3), 3'd0);
    sen.sync(1'b1, 1'b1);
    px(1'b0, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk(9'(q.size()), 9'd0);
    test_done;
  end
endmodule
`default_nettype wire
